// >>> hdl/ptimer_defs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef PTIMER_DEFS_SVH
`define PTIMER_DEFS_SVH
// Byte offsets of the register words
`define OFF_MODE     8'h00
`define OFF_CLKSEL   8'h04
`define OFF_T0CTL    8'h08
`define OFF_T1CTL    8'h0c
`define OFF_RELOAD0  8'h10
`define OFF_RELOAD1  8'h14
`define OFF_COUNT0   8'h18
`define OFF_COUNT1   8'h1c
`define OFF_IRQEN    8'h20
`define OFF_IRQFLAG  8'h24
// Field positions
`define BIT_POLARITY 0
`define BIT_FILTER   1
`define BIT_EVENT    2
`define BIT_WIDTH16  3
`define BIT_SRC0     0
`define BIT_SRC1     1
`define BIT_OUTEN    2
`define BIT_OUT_CHANNEL_SELECT    3
`define BIT_RUN      0
`define BIT_RELOAD   1
`define RATIO_LO     2
// Reset values
`define RST_BYTE     8'h00
// Prescaler division lengths minus one
`define DIV4_MAX     8'h03
`define DIV32_MAX    8'h1f
`define DIV256_MAX   8'hff
// Filter tick: 2048 Hz from the 125 MHz clock
`define CLK_HZ       125000000
`define FILTER_HZ    2048
`define FILTER_DIV   (`CLK_HZ / `FILTER_HZ)
`endif

// >>> hdl/ptimer_pkg.sv
// Types shared by the programmable timer
package ptimer_pkg;
    // Bus handshake state, one-hot
    typedef enum logic [2:0] {
        bus_idle = 3'b001,
        bus_wresp = 3'b010,
        bus_rresp = 3'b100
    } bus_state_t;
endpackage

// >>> hdl/dual_prescaled_down_timer.sv
// Dual 8-bit / single 16-bit prescaled down timer with AXI4-Lite slave
// Function
// (RULE1) Source bit picks low or high oscillator
// (RULE2) Ratio field divides by 1, 4, 32, 256
// (RULE3) Run bit starts prescaler ticks and counting
// (RULE4) Event mode ignores timer 0 prescaler settings
// (RULE5) Underflow sets flag; enable gates request
// (RULE6) Output toggles on each selected underflow
// (RULE7) Channel select picks timer 0 or 1
// (RULE8) Output enable drives pin, else high
// (RULE9) Software keeps port data 1, hiz 0
// (RULE10) Enable gating unsynchronised, short pulse possible
// (RULE11) Timer 1 underflows halved clock serial
// (RULE12) Software computes reload from baud formula
// (RULE13) Width bit chains counters to 16 bits
// (RULE14) Reload strobe loads counter immediately
// (RULE15) In 16-bit mode timer 0 run rules
// (RULE16) Stop keeps count; run resumes from it
// (RULE17) Low nibble read latches high nibble
// (RULE18) Underflow reloads and drives the outputs it feeds; a timer 0 underflow never drives serial_clock
// (RULE19) Mode bit: 0 timer, 1 event count
// (RULE20) Polarity: 0 falling, 1 rising edges
// (RULE21) Filter accepts change at second 2048 Hz tick
// (RULE22) Software stabilises high oscillator first
// (RULE23) Timer 1 never counts events
// (RULE24) 16-bit underflow sets timer 1 flag
// (RULE25) High byte borrows on low byte wrap
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`include "ptimer_defs.svh"
`default_nettype none
module dual_prescaled_down_timer
    import ptimer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_speed_osc,
    input wire logic high_speed_osc,
    input wire logic event_input_pin,
    output logic shared_output_pin,
    output logic serial_clock,
    output logic t0_irq_request,
    output logic t1_irq_request
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        bus_state_t bus;          // Handshake state
        logic aw_got;             // Write address held
        logic w_got;              // Write data held
        logic [7:0] waddr;        // Held write address
        logic [7:0] wdata;        // Held write data byte
        logic wstrb0;             // Held low lane strobe
        logic [1:0] bresp;        // Write response
        logic [31:0] rdata;       // Read data
        logic [1:0] rresp;        // Read response
        logic width16;            // Chained mode
        logic event_mode;         // Timer 0 counts pin edges
        logic filter_en;          // Noise rejector on
        logic polarity;           // 1 rising, 0 falling
        logic out_channel_select; // Output source timer
        logic out_enable;         // Pin driven from toggle
        logic [1:0] src;          // Per-timer source select
        logic [1:0] run;          // Per-timer run bits
        logic [1:0] ratio0;       // Timer 0 ratio
        logic [1:0] ratio1;       // Timer 1 ratio
        logic [7:0] reload0;      // Timer 0 reload data
        logic [7:0] reload1;      // Timer 1 reload data
        logic [7:0] cnt0;         // Timer 0 counter
        logic [7:0] cnt1;         // Timer 1 counter
        logic [3:0] hold0;        // Latched high nibble, timer 0
        logic [3:0] hold1;        // Latched high nibble, timer 1
        logic [1:0] irq_en;       // Interrupt enables
        logic [1:0] irq_flag;     // Sticky underflow flags
        logic [7:0] pre0;         // Prescaler 0 count
        logic [7:0] pre1;         // Prescaler 1 count
        logic [2:0] lso_sync;     // Low oscillator sync and last
        logic [2:0] hso_sync;     // High oscillator sync and last
        logic [1:0] ev_sync;      // Event pin synchroniser
        logic ev_level;           // Accepted pin level
        logic [15:0] fdiv;        // Filter tick divider
        logic [1:0] fticks;       // Ticks seen since change
        logic timer_out_signal;   // Output toggle
        logic serial_tgl;         // Serial clock toggle
        logic pin;                // Pin register
        logic [1:0] irq_req;      // Request outputs
    } state_t;

    state_t s;      // Registered state
    state_t next_s; // Next state

    logic lso_rise; // Low oscillator edge
    logic hso_rise; // High oscillator edge
    logic [1:0] src_edge; // Source edge per timer
    logic tick0;    // Timer 0 count pulse
    logic tick1;    // Timer 1 count pulse
    logic uf0;      // Timer 0 underflow
    logic uf1;      // Timer 1 (or chained) underflow
    logic sel_uf;   // Underflow feeding the output toggle
    logic wr_fire;  // Register write taking effect
    logic ftick;    // 2048 Hz tick
    logic ev_edge;  // Accepted event edge
    logic [7:0] rb; // Read-back byte

    // Prescaler terminal count from ratio field
    function automatic logic [7:0] div_max(input logic [1:0] r);
        case (r) // [RULE2]
            2'b11: div_max = `DIV256_MAX;
            2'b10: div_max = `DIV32_MAX;
            2'b01: div_max = `DIV4_MAX;
            default: div_max = 8'h00;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        rb = 8'h00;
        // Synchronisers: first stage read only by second
        next_s.lso_sync = {s.lso_sync[1:0], low_speed_osc};
        next_s.hso_sync = {s.hso_sync[1:0], high_speed_osc};
        next_s.ev_sync = {s.ev_sync[0], event_input_pin};
        lso_rise = s.lso_sync[1] & ~s.lso_sync[2];
        hso_rise = s.hso_sync[1] & ~s.hso_sync[2];
        // Source choice per timer
        src_edge[0] = s.src[0] ? hso_rise : lso_rise; // [RULE1]
        src_edge[1] = s.src[1] ? hso_rise : lso_rise; // [RULE1]

        // Filter tick divider
        ftick = (s.fdiv == 16'(`FILTER_DIV - 1));
        next_s.fdiv = ftick ? 16'h0000 : s.fdiv + 16'h0001;

        // Event level acceptance, with or without rejector
        ev_edge = 1'b0;
        if (s.ev_sync[1] == s.ev_level) begin
            next_s.fticks = 2'b00;
        end else if (!s.filter_en) begin
            next_s.ev_level = s.ev_sync[1];
            ev_edge = (s.ev_sync[1] == s.polarity); // [RULE20]
        end else if (ftick) begin
            if (s.fticks == 2'b01) begin // [RULE21]
                next_s.ev_level = s.ev_sync[1];
                next_s.fticks = 2'b00;
                ev_edge = (s.ev_sync[1] == s.polarity); // [RULE20]
            end else begin
                next_s.fticks = 2'b01;
            end
        end

        // Prescaler 0 runs from run bit 0 in either mode
        tick0 = 1'b0;
        if (s.run[0] && src_edge[0]) begin // [RULE3]
            if (s.pre0 >= div_max(s.ratio0)) begin
                next_s.pre0 = 8'h00;
                tick0 = 1'b1;
            end else begin
                next_s.pre0 = s.pre0 + 8'h01;
            end
        end
        // Event mode replaces timer 0 tick
        if (s.event_mode) begin // [RULE4] [RULE19]
            tick0 = s.run[0] & ev_edge;
        end
        // Timer 1 prescaler, never events
        tick1 = 1'b0;
        if (s.run[1] && src_edge[1] && !s.width16) begin // [RULE23]
            if (s.pre1 >= div_max(s.ratio1)) begin
                next_s.pre1 = 8'h00;
                tick1 = 1'b1;
            end else begin
                next_s.pre1 = s.pre1 + 8'h01;
            end
        end

        // Counters; stop only gates ticks [RULE16]
        uf0 = 1'b0;
        uf1 = 1'b0;
        if (s.width16) begin // [RULE13] [RULE15]
            if (tick0) begin
                if (s.cnt0 == 8'h00 && s.cnt1 == 8'h00) begin // [RULE25]
                    uf1 = 1'b1;
                    next_s.cnt0 = s.reload0;
                    next_s.cnt1 = s.reload1;
                end else begin
                    next_s.cnt0 = s.cnt0 - 8'h01;
                    if (s.cnt0 == 8'h00) begin // [RULE25]
                        next_s.cnt1 = s.cnt1 - 8'h01;
                    end
                end
            end
        end else begin
            if (tick0) begin
                if (s.cnt0 == 8'h00) begin // [RULE18]
                    uf0 = 1'b1;
                    next_s.cnt0 = s.reload0;
                end else begin
                    next_s.cnt0 = s.cnt0 - 8'h01;
                end
            end
            if (tick1) begin
                if (s.cnt1 == 8'h00) begin // [RULE18]
                    uf1 = 1'b1;
                    next_s.cnt1 = s.reload1;
                end else begin
                    next_s.cnt1 = s.cnt1 - 8'h01;
                end
            end
        end

        // Output toggle and serial clock from underflows
        sel_uf = s.out_channel_select ? uf1 : uf0; // [RULE7]
        if (sel_uf) begin // [RULE6]
            next_s.timer_out_signal = ~s.timer_out_signal;
        end
        if (uf1) begin // [RULE11]
            next_s.serial_tgl = ~s.serial_tgl;
        end
        // Pin gating, not aligned to the toggle [RULE10]
        next_s.pin = s.out_enable ? s.timer_out_signal : 1'b1; // [RULE8]

        // Bus channels
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wstrb0 = s_axi_wstrb[0];
        end
        wr_fire = (s.bus == bus_idle) && s.aw_got && s.w_got;

        // Flags: hardware set wins over software clear [RULE5] [RULE24]
        if (wr_fire && s.wstrb0 && s.waddr == `OFF_IRQFLAG) begin
            next_s.irq_flag = s.irq_flag & ~s.wdata[1:0];
        end
        next_s.irq_flag = next_s.irq_flag | {uf1, uf0};
        next_s.irq_req = s.irq_flag & s.irq_en; // [RULE5]

        case (s.bus)
            bus_idle: begin
                if (wr_fire) begin
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                    next_s.bus = bus_wresp;
                    next_s.bresp = 2'b00;
                    if (s.wstrb0) begin
                        case (s.waddr)
                            `OFF_MODE: begin
                                next_s.polarity = s.wdata[`BIT_POLARITY];
                                next_s.filter_en = s.wdata[`BIT_FILTER];
                                next_s.event_mode = s.wdata[`BIT_EVENT];
                                next_s.width16 = s.wdata[`BIT_WIDTH16];
                            end
                            `OFF_CLKSEL: begin
                                next_s.src[0] = s.wdata[`BIT_SRC0];
                                next_s.src[1] = s.wdata[`BIT_SRC1];
                                next_s.out_enable = s.wdata[`BIT_OUTEN];
                                next_s.out_channel_select =
                                    s.wdata[`BIT_OUT_CHANNEL_SELECT];
                            end
                            `OFF_T0CTL: begin
                                next_s.run[0] = s.wdata[`BIT_RUN];
                                next_s.ratio0 = s.wdata[3:2];
                                if (s.wdata[`BIT_RELOAD]) begin // [RULE14]
                                    next_s.cnt0 = s.reload0;
                                end
                            end
                            `OFF_T1CTL: begin
                                next_s.run[1] = s.wdata[`BIT_RUN];
                                next_s.ratio1 = s.wdata[3:2];
                                if (s.wdata[`BIT_RELOAD]) begin // [RULE14]
                                    next_s.cnt1 = s.reload1;
                                end
                            end
                            `OFF_RELOAD0: next_s.reload0 = s.wdata;
                            `OFF_RELOAD1: next_s.reload1 = s.wdata;
                            `OFF_IRQEN: next_s.irq_en = s.wdata[1:0];
                            `OFF_IRQFLAG: begin
                                // Clear handled above
                            end
                            `OFF_COUNT0, `OFF_COUNT1: begin
                                // Read-only words
                            end
                            default: next_s.bresp = 2'b10;
                        endcase
                    end
                end else if (s_axi_arvalid) begin
                    next_s.bus = bus_rresp;
                    next_s.rresp = 2'b00;
                    case (s_axi_araddr)
                        `OFF_MODE: rb = {4'h0, s.width16, s.event_mode,
                            s.filter_en, s.polarity};
                        `OFF_CLKSEL: rb = {4'h0, s.out_channel_select,
                            s.out_enable, s.src[1], s.src[0]};
                        `OFF_T0CTL: rb = {4'h0, s.ratio0, 1'b0, s.run[0]};
                        `OFF_T1CTL: rb = {4'h0, s.ratio1, 1'b0, s.run[1]};
                        `OFF_RELOAD0: rb = s.reload0;
                        `OFF_RELOAD1: rb = s.reload1;
                        `OFF_COUNT0: begin
                            // Low nibble read latches high [RULE17]
                            rb = {s.cnt0[7:4], s.cnt0[3:0]};
                            next_s.hold0 = s.cnt0[7:4];
                        end
                        `OFF_COUNT1: begin
                            rb = {s.cnt1[7:4], s.cnt1[3:0]};
                            next_s.hold1 = s.cnt1[7:4]; // [RULE17]
                        end
                        8'h28: rb = {4'h0, s.hold0};
                        8'h2c: rb = {4'h0, s.hold1};
                        `OFF_IRQEN: rb = {6'h00, s.irq_en};
                        `OFF_IRQFLAG: rb = {6'h00, s.irq_flag};
                        default: next_s.rresp = 2'b10;
                    endcase
                    next_s.rdata = {24'h000000, rb};
                end
            end
            bus_wresp: begin
                if (s_axi_bready) begin
                    next_s.bus = bus_idle;
                end
            end
            bus_rresp: begin
                if (s_axi_rready) begin
                    next_s.bus = bus_idle;
                end
            end
            default: next_s.bus = bus_idle;
        endcase
        // In chained mode the timer 1 run bit is unused [RULE15]
        if (s.width16) begin
            next_s.pre1 = 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.bus <= bus_idle;
            s.pin <= 1'b1;
            s.lso_sync <= 3'b000;
        end else begin
            s <= next_s;
        end
    end

    // Outputs from flip-flops; s_axi_arready decoded from bus state, aw_got and w_got
    assign s_axi_awready = ~s.aw_got;
    assign s_axi_wready = ~s.w_got;
    // One-hot state bits drive the response valids directly
    assign s_axi_bvalid = s.bus[1];
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = (s.bus == bus_idle) & ~(s.aw_got & s.w_got);
    assign s_axi_rvalid = s.bus[2];
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign shared_output_pin = s.pin;
    assign serial_clock = s.serial_tgl;
    assign t0_irq_request = s.irq_req[0];
    assign t1_irq_request = s.irq_req[1];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        uf0 |=> s.irq_flag[0]) else $error("flag 0 not set"); // [RULE5]
    a_req_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        s.irq_req[1] |-> $past(s.irq_en[1])) // [RULE5]
        else $error("request not gated");
    a_out_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_uf |=> s.timer_out_signal != $past(s.timer_out_signal))
        else $error("no toggle"); // [RULE6]
    a_pin_high: assert property (@(posedge aclk) disable iff (!aresetn)
        !s.out_enable |=> s.pin) else $error("pin not high"); // [RULE8]
    a_serial_uf: assert property (@(posedge aclk) disable iff (!aresetn)
        uf1 |=> $changed(s.serial_tgl)) // [RULE11]
        else $error("serial clock missed");
    a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s.run[0] && !wr_fire) |=> $stable(s.cnt0))
        else $error("count moved while stopped"); // [RULE16]
    a_reload_uf: assert property (@(posedge aclk) disable iff (!aresetn)
        (uf0 && !wr_fire) |=> s.cnt0 == $past(s.reload0))
        else $error("no reload"); // [RULE18]
    a_t1_no_event: assert property (@(posedge aclk) disable iff (!aresetn)
        tick1 |-> (src_edge[1] && !s.width16)) // [RULE23]
        else $error("timer 1 bad tick");
    a_chain_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        s.width16 |-> !uf0) else $error("t0 flag in 16-bit"); // [RULE24]
    c_uf0: cover property (@(posedge aclk) uf0);
    c_uf1_chain: cover property (@(posedge aclk) uf1 && s.width16);
    c_event: cover property (@(posedge aclk) ev_edge && s.event_mode);
    c_pin: cover property (@(posedge aclk) s.out_enable && !s.pin);

endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the dual prescaled down timer
`include "ptimer_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic lo_osc = 1'b0, hi_osc = 1'b0, ev = 1'b0;
    logic pin, sclk, irq0, irq1;
    int num_errors = 0, comparisons = 0, lo_cnt = 0, hi_cnt = 0;
    // ----------------------------------------
    // Design and clocks
    // ----------------------------------------
    dual_prescaled_down_timer uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .low_speed_osc(lo_osc), .high_speed_osc(hi_osc),
        .event_input_pin(ev), .shared_output_pin(pin),
        .serial_clock(sclk), .t0_irq_request(irq0), .t1_irq_request(irq1));
    initial begin
        forever #4 aclk = ~aclk;
    end
    // Slow source: period 10 cycles, fast source: period 6 cycles
    always @(posedge aclk) begin
        lo_cnt <= (lo_cnt == 4) ? 0 : lo_cnt + 1;
        hi_cnt <= (hi_cnt == 2) ? 0 : hi_cnt + 1;
        if (lo_cnt == 4) begin
            lo_osc <= ~lo_osc;
        end
        if (hi_cnt == 2) begin
            hi_osc <= ~hi_osc;
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        num_errors++;
        $display("BAD %0t wait for %s ran out", $time, what);
        finish_test();
    endtask
    // Bus write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 100) hang("write");
    endtask
    // Bus read: result left in rd and resp
    task automatic rg(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (i == 100) hang("read");
    endtask
    // Measures cycles between the second and third change of a line
    task automatic gap(input bit use_pin, input int exp, input string w);
        int n, e, k;
        logic prev;
        prev = use_pin ? pin : sclk;
        e = 0;
        n = 0;
        for (k = 0; k < 20000 && e < 3; k++) begin
            @(posedge aclk);
            n++;
            if ((use_pin ? pin : sclk) !== prev) begin
                prev = ~prev;
                e++;
                if (e < 3) n = 0;
            end
        end
        if (e < 3) hang(w);
        chk(n, exp, w);
    endtask
    // One high pulse of w cycles on the event input
    task automatic pulse(input int w);
        @(posedge aclk);
        ev <= 1'b1;
        repeat (w) @(posedge aclk);
        ev <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rg(`OFF_MODE);
        chk(rd, 32'h0, "mode after reset");
        chk(pin, 1'b1, "pin after reset");
        rg(8'h40);
        chk(resp, 2'b10, "unmapped read");
    endtask
    task automatic t_period;
        int div[4] = '{1, 4, 32, 256};
        wr(`OFF_RELOAD1, 32'h02);
        // Fast source already stable in the bench
        wr(`OFF_CLKSEL, 32'h0a);
        for (int r = 3; r >= 0; r--) begin
            wr(`OFF_T1CTL, {r[29:0], 2'b11});
            gap(0, 18 * div[r], "serial period");
        end
        chk(pin, 1'b1, "pin held high");
        // Port data and hiz bits lie outside the block
        wr(`OFF_CLKSEL, 32'h0e);
        gap(1, 18, "pin period");
        wr(`OFF_CLKSEL, 32'h0c);
        gap(0, 30, "slow source period");
        wr(`OFF_CLKSEL, 32'h04);
        // Let a toggle launched before the switch reach the pin
        repeat (2) @(posedge aclk);
        rd = pin;
        repeat (100) @(posedge aclk);
        chk(pin, rd[0], "pin follows stopped timer 0");
        chk(irq1, 1'b0, "masked request");
        wr(`OFF_T1CTL, 32'h0);
        wr(`OFF_IRQFLAG, 32'h3);
    endtask
    task automatic t_event;
        wr(`OFF_MODE, 32'h04);
        wr(`OFF_RELOAD0, 32'h05);
        wr(`OFF_T0CTL, 32'h02);
        rg(`OFF_COUNT0);
        chk(rd, 32'h05, "strobe load");
        wr(`OFF_T0CTL, 32'h01);
        pulse(6);
        pulse(6);
        rg(`OFF_COUNT0);
        chk(rd, 32'h03, "falling edges");
        wr(`OFF_MODE, 32'h05);
        pulse(6);
        rg(`OFF_COUNT0);
        chk(rd, 32'h02, "rising edge");
        wr(`OFF_MODE, 32'h07);
        pulse(2);
        rg(`OFF_COUNT0);
        chk(rd, 32'h02, "glitch rejected");
        wr(`OFF_MODE, 32'h05);
        wr(`OFF_T0CTL, 32'h00);
        pulse(6);
        rg(`OFF_COUNT0);
        chk(rd, 32'h02, "held while stopped");
        wr(`OFF_T0CTL, 32'h01);
        repeat (3) pulse(6);
        rg(`OFF_COUNT0);
        chk(rd, 32'h05, "reload on underflow");
        rg(`OFF_IRQFLAG);
        chk(rd, 32'h01, "flag set while masked");
        chk(irq0, 1'b0, "no masked request");
        wr(`OFF_IRQFLAG, 32'h3);
        wr(`OFF_T0CTL, 32'h00);
    endtask
    task automatic t_chain;
        wr(`OFF_MODE, 32'h0c);
        wr(`OFF_IRQEN, 32'h02);
        wr(`OFF_RELOAD0, 32'h00);
        wr(`OFF_RELOAD1, 32'h01);
        wr(`OFF_T1CTL, 32'h02);
        wr(`OFF_T0CTL, 32'h03);
        pulse(6);
        rg(`OFF_COUNT0);
        chk(rd, 32'hff, "low byte wraps");
        rg(8'h28);
        chk(rd, 32'h0f, "high nibble latched");
        rg(`OFF_COUNT1);
        chk(rd, 32'h00, "high byte borrows");
        repeat (256) pulse(6);
        rg(`OFF_COUNT1);
        chk(rd, 32'h01, "16-bit reload");
        rg(`OFF_IRQFLAG);
        chk(rd, 32'h02, "16-bit flag");
        chk(irq1, 1'b1, "enabled request");
        wr(`OFF_IRQFLAG, 32'h2);
        repeat (2) @(posedge aclk);
        chk(irq1, 1'b0, "request cleared");
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_period();
        t_event();
        t_chain();
        finish_test();
    end
endmodule
`default_nettype wire
